// ---- logic/syndrome_pkg.sv ----
// constants for the stage 2 fault syndrome capture block
package syndrome_pkg;
  // register offsets, byte addresses inside the context bank
  localparam logic [11:0] off_far_lo = 12'h060;
  localparam logic [11:0] off_far_hi = 12'h064;
  localparam logic [11:0] off_syn_primary = 12'h068;
  localparam logic [11:0] off_syn_secondary = 12'h06C;
  localparam logic [11:0] off_ipafar_lo = 12'h070;
  localparam logic [11:0] off_ipafar_hi = 12'h074;
  localparam logic [11:0] off_config = 12'hD00;
  // primary syndrome field positions
  localparam int bank_lsb = 16;
  localparam int bank_msb = 23;
  localparam int bit_async = 11;
  localparam int bit_walk_ext = 10;
  localparam int bit_xlate_op = 9;
  localparam int bit_nonsecure = 8;
  localparam int bit_instr = 6;
  localparam int bit_priv = 5;
  localparam int bit_write = 4;
  localparam int bit_two_stage_flag_walk = 3;
  localparam int bit_two_stage = 2;
  localparam int level_lsb = 0;
  localparam int level_msb = 1;
  // implemented bank index width and storage width
  localparam int bank_width = 4;
  localparam int bank_field = 8;
  localparam int addr_width = 48;
  // strap settling: the first edge takes the strap, the count stops at done
  localparam logic [1:0] strap_first = 2'h0;
  localparam logic [1:0] strap_step = 2'h1;
  localparam logic [1:0] strap_done = 2'h2;
  // table levels
  localparam logic [1:0] level_one = 2'h1;
  // fault kinds reported by the walker
  typedef enum logic [2:0] {
    kind_translation = 3'b000,
    kind_access = 3'b001,
    kind_permission = 3'b010,
    kind_walk_external = 3'b011,
    kind_other = 3'b100
  } fault_kind_t;
  localparam logic [31:0] reset_word = 32'h0000_0000;
endpackage

// ---- logic/fault_syndrome_capture.sv ----
// stage 2 fault syndrome capture with register port
// Contract
// - two_stage_flag fault records stage 1 bank index
// - only low bank index bits are stored
// - bank index ignores writes without nesting
// - bit 11 marks asynchronous recording
// - bit 10 only for external walk fault
// - bit 9 marks translation operation fault
// - bit 8 captures nonsecure attribute
// - bit 6 instruction fetch versus data
// - bit 5 privileged versus unprivileged
// - bit 4 write versus read
// - far atomic shows single missing permission
// - bit 3 stage 2 fault on stage 1 walk
// - two_stage_flag walk bit undefined without nesting
// - bit 2 marks two stage translation
// - single stage loads both addresses with ipa
// - two_stage_flag loads va, bank, and ipa
// - nesting bit zero without nesting support
// - bits 1:0 give table level
// - walk fault reports walk level
// - disabled or out of range reports level 1
// - access flag fault reports its level
// - permission fault reports final level
`timescale 1ns/10ps
`default_nettype none

module fault_syndrome_capture (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // strap: two_stage_flag translation supported
  input wire logic two_stage_supported,
  // fault report from the translation pipeline
  input wire logic fault_valid,
  input wire logic fault_async,
  input wire syndrome_pkg::fault_kind_t fault_kind,
  input wire logic fault_walk_disabled,
  input wire logic fault_out_of_range,
  input wire logic [1:0] fault_walk_level,
  input wire logic [1:0] fault_final_level,
  input wire logic fault_xlate_op,
  input wire logic fault_nonsecure,
  input wire logic fault_instr,
  input wire logic fault_priv,
  input wire logic fault_write,
  input wire logic fault_far_atomic,
  input wire logic fault_read_missing,
  input wire logic fault_write_missing,
  input wire logic fault_two_stage_flag_walk,
  input wire logic fault_two_stage,
  input wire logic [7:0] fault_stage1_bank,
  input wire logic [47:0] fault_va,
  input wire logic [47:0] fault_ipa,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // captured state for the rest of the bank
  output logic fault_captured,
  output logic [47:0] fault_address_reg,
  output logic [47:0] intermediate_fault_address_reg
);

  ////////////////////////////////////////////////////////////////////////
  // state

  // all state but the strap settling count in one record
  typedef struct packed {
    logic two_stage_flag_ok;                 // strap copy taken after reset
    logic [3:0] bank;                // stage 1 bank index, low bits only
    logic async_record_flag;
    logic walk_external_fault;
    logic xlate_operation_fault;
    logic nonsecure_flag;
    logic instruction_flag;
    logic privileged_flag;
    logic write_flag;
    logic two_stage_flag_walk_fault;
    logic two_stage_flag;
    logic [1:0] fault_table_level;
    logic [31:0] secondary;          // free scratch syndrome word
    logic [47:0] far;
    logic [47:0] ipafar;
    logic captured;                  // one cycle pulse per capture
    logic [31:0] rdata;
  } state_t;

  state_t cur;      // registered state
  state_t next_cur; // next value

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // level picked from fault kind
  function automatic logic [1:0] pick_level(
    input syndrome_pkg::fault_kind_t kind,
    input logic disabled,
    input logic out_range,
    input logic [1:0] walk_lvl,
    input logic [1:0] final_lvl
  );
    logic [1:0] lvl;
    lvl = walk_lvl;
    case (kind)
      syndrome_pkg::kind_translation: begin
        if (disabled || out_range) begin
          lvl = syndrome_pkg::level_one;
        end else begin
          lvl = walk_lvl;
        end
      end
      syndrome_pkg::kind_access: lvl = walk_lvl;
      syndrome_pkg::kind_permission: lvl = final_lvl;
      default: lvl = walk_lvl;
    endcase
    return lvl;
  endfunction

  // direction bit, atomics report the lone missing permission
  function automatic logic pick_write(
    input logic atomic,
    input logic rd_miss,
    input logic wr_miss,
    input logic wr
  );
    logic w;
    if (atomic) begin
      w = wr_miss && !rd_miss;
    end else begin
      w = wr;
    end
    return w;
  endfunction

  // primary syndrome word from the record
  function automatic logic [31:0] pack_primary(input state_t s);
    logic [31:0] w;
    w = syndrome_pkg::reset_word;
    w[syndrome_pkg::bank_lsb +: syndrome_pkg::bank_width] = s.bank;
    w[syndrome_pkg::bit_async] = s.async_record_flag;
    w[syndrome_pkg::bit_walk_ext] = s.walk_external_fault;
    w[syndrome_pkg::bit_xlate_op] = s.xlate_operation_fault;
    w[syndrome_pkg::bit_nonsecure] = s.nonsecure_flag;
    w[syndrome_pkg::bit_instr] = s.instruction_flag;
    w[syndrome_pkg::bit_priv] = s.privileged_flag;
    w[syndrome_pkg::bit_write] = s.write_flag;
    w[syndrome_pkg::bit_two_stage_flag_walk] = s.two_stage_flag_walk_fault;
    w[syndrome_pkg::bit_two_stage] = s.two_stage_flag & s.two_stage_flag_ok;
    w[syndrome_pkg::level_msb:syndrome_pkg::level_lsb] = s.fault_table_level;
    return w;
  endfunction

  logic [1:0] strap_wait; // counts edges after reset release

  ////////////////////////////////////////////////////////////////////////
  // strap capture, taken by a clocked process after release
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strap_wait <= syndrome_pkg::strap_first;
    end else if (strap_wait != syndrome_pkg::strap_done) begin
      strap_wait <= strap_wait + syndrome_pkg::strap_step;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic nest;
    nest = cur.two_stage_flag_ok;
    next_cur = cur;
    next_cur.captured = 1'b0;
    next_cur.rdata = syndrome_pkg::reset_word;
    // strap is sampled once on the first edge after release
    if (strap_wait == syndrome_pkg::strap_first) begin
      next_cur.two_stage_flag_ok = two_stage_supported;
    end
    // software writes; a capture in the same cycle overrides below
    if (reg_write) begin
      if (reg_addr == syndrome_pkg::off_syn_primary) begin
        if (nest) begin
          next_cur.bank = reg_wdata[syndrome_pkg::bank_lsb +: syndrome_pkg::bank_width];
          next_cur.two_stage_flag = reg_wdata[syndrome_pkg::bit_two_stage];
        end
        next_cur.two_stage_flag_walk_fault = reg_wdata[syndrome_pkg::bit_two_stage_flag_walk];
        next_cur.async_record_flag = reg_wdata[syndrome_pkg::bit_async];
        next_cur.walk_external_fault = reg_wdata[syndrome_pkg::bit_walk_ext];
        next_cur.xlate_operation_fault = reg_wdata[syndrome_pkg::bit_xlate_op];
        next_cur.nonsecure_flag = reg_wdata[syndrome_pkg::bit_nonsecure];
        next_cur.instruction_flag = reg_wdata[syndrome_pkg::bit_instr];
        next_cur.privileged_flag = reg_wdata[syndrome_pkg::bit_priv];
        next_cur.write_flag = reg_wdata[syndrome_pkg::bit_write];
        next_cur.fault_table_level = reg_wdata[syndrome_pkg::level_msb:syndrome_pkg::level_lsb];
      end else if (reg_addr == syndrome_pkg::off_syn_secondary) begin
        next_cur.secondary = reg_wdata;
      end else if (reg_addr == syndrome_pkg::off_far_lo) begin
        next_cur.far[31:0] = reg_wdata;
      end else if (reg_addr == syndrome_pkg::off_far_hi) begin
        next_cur.far[47:32] = reg_wdata[15:0];
      end else if (reg_addr == syndrome_pkg::off_ipafar_lo && nest) begin
        next_cur.ipafar[31:0] = reg_wdata;
      end else if (reg_addr == syndrome_pkg::off_ipafar_hi && nest) begin
        next_cur.ipafar[47:32] = reg_wdata[15:0];
      end
    end
    // fault capture: all fields but secondary load in this one cycle; bank only for two_stage_flag faults
    if (fault_valid) begin
      next_cur.captured = 1'b1;
      next_cur.async_record_flag = fault_async;
      next_cur.walk_external_fault = (fault_kind == syndrome_pkg::kind_walk_external);
      next_cur.xlate_operation_fault = fault_xlate_op;
      next_cur.nonsecure_flag = fault_nonsecure;
      next_cur.instruction_flag = fault_instr;
      next_cur.privileged_flag = fault_priv;
      next_cur.write_flag = pick_write(fault_far_atomic, fault_read_missing,
                                       fault_write_missing, fault_write);
      next_cur.two_stage_flag_walk_fault = fault_two_stage_flag_walk & nest;
      next_cur.two_stage_flag = fault_two_stage & nest;
      next_cur.fault_table_level = pick_level(fault_kind, fault_walk_disabled,
                                              fault_out_of_range, fault_walk_level,
                                              fault_final_level);
      next_cur.ipafar = fault_ipa;
      if (fault_two_stage && nest) begin
        next_cur.far = fault_va;
        next_cur.bank = fault_stage1_bank[syndrome_pkg::bank_width-1:0];
      end else begin
        next_cur.far = fault_ipa;
        next_cur.bank = cur.bank; // left as is, contents undefined
      end
    end
    // reads: data stand one cycle after the strobe
    if (reg_read) begin
      if (reg_addr == syndrome_pkg::off_syn_primary) begin
        next_cur.rdata = pack_primary(cur);
      end else if (reg_addr == syndrome_pkg::off_syn_secondary) begin
        next_cur.rdata = cur.secondary;
      end else if (reg_addr == syndrome_pkg::off_far_lo) begin
        next_cur.rdata = cur.far[31:0];
      end else if (reg_addr == syndrome_pkg::off_far_hi) begin
        next_cur.rdata = {16'h0000, cur.far[47:32]};
      end else if (reg_addr == syndrome_pkg::off_ipafar_lo) begin
        // without nesting this is an alias of the fault address
        next_cur.rdata = nest ? cur.ipafar[31:0] : cur.far[31:0];
      end else if (reg_addr == syndrome_pkg::off_ipafar_hi) begin
        next_cur.rdata = {16'h0000, nest ? cur.ipafar[47:32] : cur.far[47:32]};
      end else if (reg_addr == syndrome_pkg::off_config) begin
        next_cur.rdata = {31'h0000_0000, nest};
      end else begin
        next_cur.rdata = syndrome_pkg::reset_word; // unmapped reads zero
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the record
  assign reg_rdata = cur.rdata;
  assign fault_captured = cur.captured;
  assign fault_address_reg = cur.far;
  assign intermediate_fault_address_reg = cur.ipafar;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_two_stage_flag_fault;
    fault_valid && fault_two_stage && cur.two_stage_flag_ok;
  endsequence

  a_bank_index_two_stage_flag: assert property (@(posedge clock) disable iff (!reset_n)
    s_two_stage_flag_fault |=> cur.bank == $past(fault_stage1_bank[syndrome_pkg::bank_width-1:0]))
    else $error("bank index not captured");

  a_bank_write_ignored: assert property (@(posedge clock) disable iff (!reset_n)
    (!cur.two_stage_flag_ok && !fault_valid && strap_wait == syndrome_pkg::strap_done)
      |=> $stable(cur.bank))
    else $error("bank index changed without nesting");

  a_async_flag: assert property (@(posedge clock) disable iff (!reset_n)
    fault_valid |=> cur.async_record_flag == $past(fault_async))
    else $error("async flag wrong");

  a_walk_ext_flag: assert property (@(posedge clock) disable iff (!reset_n)
    fault_valid |=>
      cur.walk_external_fault == ($past(fault_kind) == syndrome_pkg::kind_walk_external))
    else $error("walk external flag wrong");

  a_atomic_direction: assert property (@(posedge clock) disable iff (!reset_n)
    fault_valid && fault_far_atomic && fault_read_missing |=> !cur.write_flag)
    else $error("atomic direction wrong");

  a_two_stage_zero: assert property (@(posedge clock) disable iff (!reset_n)
    !cur.two_stage_flag_ok && strap_wait == syndrome_pkg::strap_done |-> ##1 !cur.two_stage_flag [*2])
    else $error("nesting flag set without support");

  a_single_stage_addr: assert property (@(posedge clock) disable iff (!reset_n)
    fault_valid && !fault_two_stage
      |=> cur.far == $past(fault_ipa) && cur.ipafar == $past(fault_ipa))
    else $error("single stage addresses differ");

  a_level_disabled: assert property (@(posedge clock) disable iff (!reset_n)
    fault_valid && fault_kind == syndrome_pkg::kind_translation && fault_walk_disabled
      |=> cur.fault_table_level == syndrome_pkg::level_one)
    else $error("disabled walk level not one");

  a_capture_pulse: assert property (@(posedge clock) disable iff (!reset_n)
    fault_valid |=> fault_captured && cur.nonsecure_flag == $past(fault_nonsecure))
    else $error("capture not atomic");

  ////////////////////////////////////////////////////////////////////////
  // per field checks, each seen the cycle after the report, then the read data and strap copy checks

  // any fault report taken at this edge
  sequence s_any_fault;
    fault_valid;
  endsequence

  // operation origin follows the report
  a_xlate_op_flag: assert property (@(posedge clock) disable iff (!reset_n)
    s_any_fault |=> cur.xlate_operation_fault == $past(fault_xlate_op))
    else $error("translation operation flag wrong");

  // security attribute follows the report
  a_nonsecure_flag: assert property (@(posedge clock) disable iff (!reset_n)
    s_any_fault |=> cur.nonsecure_flag == $past(fault_nonsecure))
    else $error("nonsecure flag wrong");

  // instruction fetch versus data follows the report
  a_instr_flag: assert property (@(posedge clock) disable iff (!reset_n)
    s_any_fault |=> cur.instruction_flag == $past(fault_instr))
    else $error("instruction flag wrong");

  // privilege follows the report
  a_priv_flag: assert property (@(posedge clock) disable iff (!reset_n)
    s_any_fault |=> cur.privileged_flag == $past(fault_priv))
    else $error("privileged flag wrong");

  // plain accesses keep their own direction, atomics with a missing read are checked above
  a_plain_direction: assert property (@(posedge clock) disable iff (!reset_n)
    fault_valid && !fault_far_atomic |=> cur.write_flag == $past(fault_write))
    else $error("direction flag wrong");

  // walk fault bit follows the report only while nesting is on
  a_two_stage_flag_walk_bit: assert property (@(posedge clock) disable iff (!reset_n)
    fault_valid && cur.two_stage_flag_ok |=> cur.two_stage_flag_walk_fault == $past(fault_two_stage_flag_walk))
    else $error("two_stage_flag walk bit wrong");

  // nesting flag follows the report while nesting is on
  a_two_stage_flag: assert property (@(posedge clock) disable iff (!reset_n)
    fault_valid && cur.two_stage_flag_ok |=> cur.two_stage_flag == $past(fault_two_stage))
    else $error("nesting flag wrong");

  // a two_stage_flag fault puts the requested address in the fault address
  a_two_stage_flag_va: assert property (@(posedge clock) disable iff (!reset_n)
    s_two_stage_flag_fault |=> cur.far == $past(fault_va))
    else $error("two_stage_flag fault address wrong");

  // access flag faults give the level of the faulting table
  a_level_access: assert property (@(posedge clock) disable iff (!reset_n)
    fault_valid && fault_kind == syndrome_pkg::kind_access
      |=> cur.fault_table_level == $past(fault_walk_level))
    else $error("access fault level wrong");

  // permission faults give the final table level
  a_level_permission: assert property (@(posedge clock) disable iff (!reset_n)
    fault_valid && fault_kind == syndrome_pkg::kind_permission
      |=> cur.fault_table_level == $past(fault_final_level))
    else $error("permission fault level wrong");

  // read data stand one cycle only, so a stale word cannot be taken twice
  a_read_one_cycle: assert property (@(posedge clock) disable iff (!reset_n)
    !reg_read |=> reg_rdata == syndrome_pkg::reset_word)
    else $error("read data held too long");

  // the strap copy is frozen once taken
  a_strap_frozen: assert property (@(posedge clock) disable iff (!reset_n)
    strap_wait == syndrome_pkg::strap_done |=> $stable(cur.two_stage_flag_ok))
    else $error("strap copy changed");

endmodule

`default_nettype wire

// ---- tb/fault_source.sv ----
// upstream model that reports translation faults to the capture block
`timescale 1ns/10ps
`default_nettype none

module fault_source (
  // clock
  input wire logic clock,
  // fault report toward the capture block
  output var logic fault_valid,
  output var logic [12:0] flags,
  output var syndrome_pkg::fault_kind_t fault_kind,
  output var logic [1:0] walk_level,
  output var logic [1:0] final_level,
  output var logic [7:0] bank,
  output var logic [47:0] va,
  output var logic [47:0] ipa
);
  // idle report at time zero
  initial begin
    fault_valid = 1'b0;
    flags = 13'h0000;
    fault_kind = syndrome_pkg::kind_other;
    walk_level = 2'h0;
    final_level = 2'h0;
    bank = 8'h00;
    va = 48'h0000_0000_0000;
    ipa = 48'h0000_0000_0000;
  end

  // one strobe cycle; attributes are scrambled after it so a stale value cannot pass
  task automatic issue(input logic [12:0] f, input syndrome_pkg::fault_kind_t k,
                       input logic [1:0] lw, input logic [1:0] lf, input logic [7:0] b,
                       input logic [47:0] v, input logic [47:0] p);
    @(posedge clock);
    fault_valid <= 1'b1;
    flags <= f;
    fault_kind <= k;
    walk_level <= lw;
    final_level <= lf;
    bank <= b;
    va <= v;
    ipa <= p;
    @(posedge clock);
    fault_valid <= 1'b0;
    flags <= ~f;
    fault_kind <= syndrome_pkg::kind_other;
    walk_level <= ~lw;
    final_level <= ~lf;
    bank <= ~b;
    va <= ~v;
    ipa <= ~p;
  endtask
endmodule

`default_nettype wire

// ---- tb/tb_stage2_fault_syndrome_capture.sv ----
// register and fault port tests for the fault syndrome capture block
`timescale 1ns/10ps
`default_nettype none

`define CHECK(n, e, a) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", n, e, a); end end

module tb_stage2_fault_syndrome_capture;
  // clock, reset, strap and register port
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic two_stage_supported = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic fault_captured;
  logic [47:0] fault_address_reg;
  logic [47:0] intermediate_fault_address_reg;
  // fault report from the model
  logic fault_valid;
  logic [12:0] flags;
  syndrome_pkg::fault_kind_t fault_kind;
  logic [1:0] walk_level;
  logic [1:0] final_level;
  logic [7:0] bank;
  logic [47:0] va;
  logic [47:0] ipa;
  int mismatches = 0;
  int compares = 0;
  logic [31:0] rd;
  // case table: flags are async,disabled,range,xop,ns,instr,priv,wr,atomic,rmiss,wmiss,nwalk,two
  localparam logic [12:0] cf [7] = '{13'h1A03, 13'h0580, 13'h0061, 13'h003D, 13'h0015,
                                     13'h0018, 13'h0120};
  localparam logic [2:0] ck [7] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
  localparam logic [1:0] clw [7] = '{2'h2, 2'h3, 2'h3, 2'h2, 2'h0, 2'h1, 2'h0};
  localparam logic [1:0] clf [7] = '{2'h3, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h1};

  always #4 clock = ~clock;

  fault_source fault_source_inst (.clock(clock), .fault_valid(fault_valid), .flags(flags),
    .fault_kind(fault_kind), .walk_level(walk_level), .final_level(final_level),
    .bank(bank), .va(va), .ipa(ipa));

  fault_syndrome_capture fault_syndrome_capture_inst (.clock(clock), .reset_n(reset_n),
    .two_stage_supported(two_stage_supported), .fault_valid(fault_valid),
    .fault_async(flags[12]), .fault_kind(fault_kind), .fault_walk_disabled(flags[11]),
    .fault_out_of_range(flags[10]), .fault_walk_level(walk_level),
    .fault_final_level(final_level), .fault_xlate_op(flags[9]), .fault_nonsecure(flags[8]),
    .fault_instr(flags[7]), .fault_priv(flags[6]), .fault_write(flags[5]),
    .fault_far_atomic(flags[4]), .fault_read_missing(flags[3]),
    .fault_write_missing(flags[2]), .fault_two_stage_flag_walk(flags[1]),
    .fault_two_stage(flags[0]), .fault_stage1_bank(bank), .fault_va(va), .fault_ipa(ipa),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .fault_captured(fault_captured),
    .fault_address_reg(fault_address_reg),
    .intermediate_fault_address_reg(intermediate_fault_address_reg));

  ////////////////////////////////////////////////////////////////////////////////
  // expected primary word, built field by field
  function automatic logic [31:0] exp_word(input logic [12:0] f, input logic [2:0] k,
      input logic [1:0] lw, input logic [1:0] lf, input logic [3:0] b, input logic s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[syndrome_pkg::bank_msb:syndrome_pkg::bank_lsb] = (s & f[0]) ? {4'h0, b} : 8'h00;
    w[syndrome_pkg::bit_async] = f[12];
    w[syndrome_pkg::bit_walk_ext] = (k == 3'h3);
    w[syndrome_pkg::bit_xlate_op] = f[9];
    w[syndrome_pkg::bit_nonsecure] = f[8];
    w[syndrome_pkg::bit_instr] = f[7];
    w[syndrome_pkg::bit_priv] = f[6];
    // far atomic reports write only when write alone is missing
    w[syndrome_pkg::bit_write] = f[4] ? (f[2] & ~f[3]) : f[5];
    w[syndrome_pkg::bit_two_stage_flag_walk] = s & f[1];
    w[syndrome_pkg::bit_two_stage] = s & f[0];
    // permission uses final level, disabled or out of range translation gives level 1
    w[1:0] = (k == 3'h2) ? lf : ((k == 3'h0 && (f[11] | f[10])) ? 2'h1 : lw);
    return w;
  endfunction

  // register port: one strobe cycle each, read data in the cycle after
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // strap is set while reset is low; three edges pass before the first request
  task automatic do_reset(input logic s);
    @(posedge clock);
    reset_n <= 1'b0;
    two_stage_supported <= s;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    reg_rd(syndrome_pkg::off_syn_primary, rd);
    `CHECK("reset primary", syndrome_pkg::reset_word, rd)
  endtask

  // every fault kind with its attributes; reserved bits and the undefined bank index are masked
  task automatic run_cases(input logic s);
    logic [47:0] v;
    logic [47:0] p;
    logic nest;
    logic [31:0] ew;
    logic [31:0] bm;
    for (int i = 0; i < 7; i++) begin
      v = 48'h1234_5678_9ABC ^ 48'(i);
      p = 48'h0FED_CBA9_8765 ^ 48'(i);
      nest = s & cf[i][0];
      fault_source_inst.issue(cf[i], syndrome_pkg::fault_kind_t'(ck[i]), clw[i], clf[i],
                              {4'hA, 4'(i)}, v, p);
      #1;
      `CHECK("captured", 1'b1, fault_captured)
      `CHECK("far", nest ? v : p, fault_address_reg)
      `CHECK("ipafar", p, intermediate_fault_address_reg)
      reg_rd(syndrome_pkg::off_syn_primary, rd);
      `CHECK("captured low", 1'b0, fault_captured)
      ew = exp_word(cf[i], ck[i], clw[i], clf[i], 4'(i), s);
      bm = nest ? 32'h00FF_0000 : 32'h0000_0000;
      `CHECK("bank", ew & bm, rd & bm)
      `CHECK("bits 11:9", ew & 32'h0000_0E00, rd & 32'h0000_0E00)
      `CHECK("attr", ew & 32'h0000_0170, rd & 32'h0000_0170)
      `CHECK("nesting", ew & 32'h0000_000C, rd & 32'h0000_000C)
      `CHECK("lvl", ew & 32'h0000_0003, rd & 32'h0000_0003)
    end
  endtask

  task automatic wrap_up;
    $display("counts: compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: two_stage_flag support on, then off
  initial begin
    do_reset(1'b1);
    run_cases(1'b1);
    reg_rd(syndrome_pkg::off_far_hi, rd);
    `CHECK("far hi", 32'h0000_0FED, rd)
    // a fault in the same cycle as a software write must win
    fork
      fault_source_inst.issue(cf[2], syndrome_pkg::kind_translation, 2'h3, 2'h0, 8'h00,
                              48'h0000_0000_0001, 48'h0000_0000_0002);
      reg_wr(syndrome_pkg::off_syn_primary, 32'h0000_0000);
    join
    reg_rd(syndrome_pkg::off_syn_primary, rd);
    `CHECK("race", 32'h0000_0037, rd & 32'h0000_0F7F)
    // read data fall back to zero one cycle later
    @(posedge clock);
    #1;
    `CHECK("rdata idle", 32'h0000_0000, reg_rdata)
    reg_wr(syndrome_pkg::off_syn_primary, 32'h00FF_0004);
    reg_rd(syndrome_pkg::off_syn_primary, rd);
    `CHECK("bank write", 32'h000F_0004, rd & 32'h00FF_0004)
    reg_rd(syndrome_pkg::off_config, rd);
    `CHECK("config", 32'h0000_0001, rd)
    reg_rd(12'h100, rd);
    `CHECK("unmapped", 32'h0000_0000, rd)
    reg_wr(syndrome_pkg::off_syn_secondary, 32'hA5A5_5A5A);
    reg_rd(syndrome_pkg::off_syn_secondary, rd);
    `CHECK("secondary", 32'hA5A5_5A5A, rd)
    reg_wr(syndrome_pkg::off_far_lo, 32'h1357_9BDF);
    reg_rd(syndrome_pkg::off_far_lo, rd);
    `CHECK("far lo", 32'h1357_9BDF, rd)
    reg_wr(syndrome_pkg::off_ipafar_hi, 32'h0000_2468);
    reg_rd(syndrome_pkg::off_ipafar_hi, rd);
    `CHECK("ipafar hi", 32'h0000_2468, rd)
    $display("test two_stage_flag done");
    do_reset(1'b0);
    run_cases(1'b0);
    reg_wr(syndrome_pkg::off_syn_primary, 32'hFFFF_FFFF);
    reg_rd(syndrome_pkg::off_syn_primary, rd);
    `CHECK("ignored write", 32'h0000_0000, rd & 32'h00FF_0004)
    reg_wr(syndrome_pkg::off_ipafar_lo, 32'h5555_5555);
    #1;
    `CHECK("ipafar kept", 48'h0FED_CBA9_8763, intermediate_fault_address_reg)
    reg_rd(syndrome_pkg::off_ipafar_lo, rd);
    `CHECK("ipafar alias", 32'hCBA9_8763, rd)
    reg_rd(syndrome_pkg::off_config, rd);
    `CHECK("config", 32'h0000_0000, rd)
    $display("test single stage done");
    wrap_up();
  end

  // watchdog well beyond the roughly 150 cycles the tests need
  initial begin
    repeat (3000) @(posedge clock);
    mismatches++;
    wrap_up();
  end
endmodule

`default_nettype wire
